// >>> logic_stack_op_pkg.sv
package logic_stack_op_pkg;

   // Instruction groups this decoder handles.
   typedef enum logic [3:0] {
      op_invert_general,
      op_invert_short,
      op_or_imm_general,
      op_or_imm_short,
      op_or_general,
      op_or_short,
      op_pop_general,
      op_pop_short,
      op_pop_control_register,
      op_pop_multiple_registers,
      op_push_imm_general,
      op_push_general,
      op_push_short,
      op_push_effective_address,
      op_push_control_register
   } opcode_t;

   // Operand classes after decoding.
   typedef enum logic [3:0] {
      mode_data_reg,
      mode_address_reg,
      mode_indirect,
      mode_disp8_address,
      mode_disp8_static_base,
      mode_disp8_frame_base,
      mode_disp16_address,
      mode_disp16_static_base,
      mode_absolute_address_mode,
      mode_control_reg,
      mode_none
   } mode_t;

   // General 4-bit operand codes.
   localparam logic [3:0] GEN_DATA_LAST = 4'h3;
   localparam logic [3:0] GEN_ADDR_FIRST = 4'h4;
   localparam logic [3:0] GEN_ADDR_SECOND = 4'h5;
   localparam logic [3:0] GEN_IND_FIRST = 4'h6;
   localparam logic [3:0] GEN_IND_SECOND = 4'h7;
   localparam logic [3:0] GEN_D8_ADDR_FIRST = 4'h8;
   localparam logic [3:0] GEN_D8_ADDR_SECOND = 4'h9;
   localparam logic [3:0] GEN_D8_STATIC = 4'hA;
   localparam logic [3:0] GEN_D8_FRAME = 4'hB;
   localparam logic [3:0] GEN_D16_ADDR_FIRST = 4'hC;
   localparam logic [3:0] GEN_D16_ADDR_SECOND = 4'hD;
   localparam logic [3:0] GEN_D16_STATIC = 4'hE;
   localparam logic [3:0] GEN_ABS = 4'hF;

   // Short 3-bit destination codes.
   localparam logic [2:0] SHORT_DATA_HIGH = 3'h3;
   localparam logic [2:0] SHORT_DATA_LOW = 3'h4;
   localparam logic [2:0] SHORT_D8_STATIC = 3'h5;
   localparam logic [2:0] SHORT_D8_FRAME = 3'h6;
   localparam logic [2:0] SHORT_ABS = 3'h7;

   // Short 2-bit source codes.
   localparam logic [1:0] SRC2_REG = 2'h0;
   localparam logic [1:0] SRC2_D8_STATIC = 2'h1;
   localparam logic [1:0] SRC2_D8_FRAME = 2'h2;
   localparam logic [1:0] SRC2_ABS = 2'h3;

   // Control register select codes.
   localparam logic [2:0] CTRL_INVALID = 3'h0;
   localparam logic [2:0] CTRL_VEC_LOW = 3'h1;
   localparam logic [2:0] CTRL_VEC_HIGH = 3'h2;
   localparam logic [2:0] CTRL_FLAG = 3'h3;
   localparam logic [2:0] CTRL_INT_STACK = 3'h4;
   localparam logic [2:0] CTRL_STACK = 3'h5;
   localparam logic [2:0] CTRL_STATIC = 3'h6;
   localparam logic [2:0] CTRL_FRAME = 3'h7;

   // Size field encoding.
   localparam logic SIZE_BYTE = 1'b0;
   localparam logic SIZE_WORD = 1'b1;

   // Cycle counts.
   localparam logic [4:0] CYC_ONE = 5'h01;
   localparam logic [4:0] CYC_OR_RR = 5'h02;
   localparam logic [4:0] CYC_OR_RM = 5'h03;
   localparam logic [4:0] CYC_OR_MR = 5'h03;
   localparam logic [4:0] CYC_OR_MM = 5'h04;
   localparam logic [4:0] CYC_MEM3 = 5'h03;
   localparam logic [4:0] CYC_MEM4 = 5'h04;
   localparam logic [4:0] CYC_OR_IMM_REG = 5'h02;
   localparam logic [4:0] CYC_OR_SHORT_REG = 5'h02;
   localparam logic [4:0] CYC_POP = 5'h03;
   localparam logic [4:0] CYC_POP_MEM = 5'h04;
   localparam logic [4:0] CYC_PUSH = 5'h02;
   localparam logic [4:0] CYC_PUSH_MEM = 5'h04;
   localparam logic [4:0] CYC_PUSH_ADDR = 5'h02;
   localparam logic [4:0] CYC_POP_CTRL = 5'h03;
   localparam logic [4:0] CYC_MULTI_POP_SINGLE = 5'h03;
   localparam logic [4:0] CYC_MULTI_POP_PER_REG = 5'h02;

   // Byte counts.
   localparam logic [2:0] LEN_ONE = 3'h1;
   localparam logic [2:0] LEN_TWO = 3'h2;
   localparam logic [2:0] LEN_THREE = 3'h3;
   localparam logic [2:0] LEN_DISP8 = 3'h1;
   localparam logic [2:0] LEN_DISP16 = 3'h2;

endpackage

// >>> logic_stack_op_decoder.sv
`timescale 1ns/10ps
`default_nettype none

// How it works
// - Codes 0000-0011 pick data registers, 0100/0101 the two address registers.
// - Codes 0110/0111 indirect, 1000-1011 eight-bit, 1100-1110 sixteen-bit displacement.
// - Code 1111 is absolute 16-bit addressing from following bytes.
// - Short destination: 011 high, 100 low, 101/110 base displacement, 111 absolute.
// - Short or: 2-bit source mode, 1-bit destination low or high byte.
// - General or: register-register 2 cycles, register to memory 3 cycles.
// - General or: memory to register 3 cycles, memory to memory 4.
// - Word size adds one immediate byte for or-immediate and push-immediate.
// - Multi-pop mask restores set bits; bit 7 frame base down to data zero.
// - Multi-pop: 3 cycles for zero or one register, else 2 per register.
// - Control select 001-111 picks vector base, flags, stack pointers, bases.
// - Effective-address push accepts only 1000-1111, always 2 cycles.
module logic_stack_op_decoder
   import logic_stack_op_pkg::*;
(
   // Clock and reset.
   input wire logic clk,
   input wire logic resetn,
   // Decode request.
   input wire logic req_valid,
   input wire opcode_t req_op,
   input wire logic req_size,
   input wire logic [3:0] req_src,
   input wire logic [3:0] req_dest,
   input wire logic [7:0] req_mask,
   // Decode result.
   output logic dec_valid,
   output logic dec_illegal,
   output logic dec_word,
   output mode_t dec_src_mode,
   output logic [2:0] dec_src_reg,
   output mode_t dec_dest_mode,
   output logic [2:0] dec_dest_reg,
   output logic [2:0] dec_bytes,
   output logic [4:0] dec_cycles,
   output logic [7:0] dec_restore_mask,
   output logic [3:0] dec_restore_count
);

   ////////////////////////////////////////////////////////////////////////
   // Operand field decode.

   function automatic mode_t gen_mode(input logic [3:0] code);
      mode_t m;
      m = mode_none;
      if (code <= GEN_DATA_LAST)
         m = mode_data_reg;
      else if (code == GEN_ADDR_FIRST || code == GEN_ADDR_SECOND)
         m = mode_address_reg;
      else if (code == GEN_IND_FIRST || code == GEN_IND_SECOND)
         m = mode_indirect;
      else if (code == GEN_D8_ADDR_FIRST || code == GEN_D8_ADDR_SECOND)
         m = mode_disp8_address;
      else if (code == GEN_D8_STATIC)
         m = mode_disp8_static_base;
      else if (code == GEN_D8_FRAME)
         m = mode_disp8_frame_base;
      else if (code == GEN_D16_ADDR_FIRST || code == GEN_D16_ADDR_SECOND)
         m = mode_disp16_address;
      else if (code == GEN_D16_STATIC)
         m = mode_disp16_static_base;
      else if (code == GEN_ABS)
         m = mode_absolute_address_mode;
      return m;
   endfunction

   // Extra operand bytes carried by a general operand code.
   function automatic logic [2:0] gen_extra(input logic [3:0] code);
      logic [2:0] n;
      n = 3'h0;
      if (code >= GEN_D16_ADDR_FIRST)
         n = LEN_DISP16;
      else if (code >= GEN_D8_ADDR_FIRST)
         n = LEN_DISP8;
      return n;
   endfunction

   // Register index within the selected bank: data register number or address register.
   function automatic logic [2:0] gen_reg(input logic [3:0] code);
      return {1'b0, code[1:0]};
   endfunction

   function automatic logic gen_is_reg(input logic [3:0] code);
      return code <= GEN_ADDR_SECOND;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Combinational decode of one request.

   logic valid_next;
   logic illegal_next;
   logic word_next;
   mode_t src_mode_next;
   mode_t dest_mode_next;
   logic [2:0] src_reg_next;
   logic [2:0] dest_reg_next;
   logic [2:0] bytes_next;
   logic [4:0] cycles_next;
   logic [7:0] mask_next;
   logic [3:0] count_next;
   logic [3:0] pop_count;

   // Count of set mask bits; a loop keeps it one adder chain.
   always_comb
   begin
      pop_count = 4'h0;
      for (int i = 0; i < 8; i++)
         pop_count = pop_count + {3'h0, req_mask[i]};
   end

   always_comb
   begin
      valid_next = req_valid;
      illegal_next = 1'b0;
      word_next = (req_size == SIZE_WORD);
      src_mode_next = mode_none;
      dest_mode_next = mode_none;
      src_reg_next = 3'h0;
      dest_reg_next = 3'h0;
      bytes_next = LEN_ONE;
      cycles_next = CYC_ONE;
      mask_next = 8'h00;
      count_next = 4'h0;
      case (req_op)
         op_invert_general, op_pop_general, op_push_general:
         begin
            dest_mode_next = gen_mode(req_dest);
            dest_reg_next = gen_reg(req_dest);
            bytes_next = LEN_TWO + gen_extra(req_dest);
            if (req_op == op_invert_general)
               cycles_next = gen_is_reg(req_dest) ? CYC_ONE : CYC_MEM3;
            else if (req_op == op_pop_general)
               cycles_next = gen_is_reg(req_dest) ? CYC_POP : CYC_POP_MEM;
            else
               cycles_next = gen_is_reg(req_dest) ? CYC_PUSH : CYC_PUSH_MEM;
         end
         op_invert_short, op_or_imm_short:
         begin
            word_next = 1'b0;
            dest_reg_next = 3'h0;
            case (req_dest[2:0])
               SHORT_DATA_HIGH:
               begin
                  dest_mode_next = mode_data_reg;
                  dest_reg_next = 3'h1;
               end
               SHORT_DATA_LOW: dest_mode_next = mode_data_reg;
               SHORT_D8_STATIC: dest_mode_next = mode_disp8_static_base;
               SHORT_D8_FRAME: dest_mode_next = mode_disp8_frame_base;
               SHORT_ABS: dest_mode_next = mode_absolute_address_mode;
               default: illegal_next = 1'b1;
            endcase
            if (req_dest[2:0] == SHORT_ABS)
               bytes_next = LEN_THREE;
            else if (req_dest[2:0] == SHORT_D8_STATIC || req_dest[2:0] == SHORT_D8_FRAME)
               bytes_next = LEN_TWO;
            else
               bytes_next = LEN_ONE;
            if (req_op == op_or_imm_short)
               bytes_next = bytes_next + LEN_ONE;
            cycles_next = (dest_mode_next == mode_data_reg) ? CYC_ONE : CYC_MEM3;
         end
         op_or_imm_general, op_push_imm_general:
         begin
            src_mode_next = mode_none;
            if (req_op == op_or_imm_general)
            begin
               dest_mode_next = gen_mode(req_dest);
               dest_reg_next = gen_reg(req_dest);
               bytes_next = LEN_THREE + gen_extra(req_dest);
               cycles_next = gen_is_reg(req_dest) ? CYC_OR_IMM_REG : CYC_MEM4;
            end
            else
            begin
               bytes_next = LEN_THREE;
               cycles_next = CYC_PUSH;
            end
            if (req_size == SIZE_WORD)
               bytes_next = bytes_next + LEN_ONE;
         end
         op_or_general:
         begin
            src_mode_next = gen_mode(req_src);
            src_reg_next = gen_reg(req_src);
            dest_mode_next = gen_mode(req_dest);
            dest_reg_next = gen_reg(req_dest);
            bytes_next = LEN_TWO + gen_extra(req_src) + gen_extra(req_dest);
            if (gen_is_reg(req_src))
               cycles_next = gen_is_reg(req_dest) ? CYC_OR_RR : CYC_OR_RM;
            else
               cycles_next = gen_is_reg(req_dest) ? CYC_OR_MR : CYC_OR_MM;
         end
         op_or_short:
         begin
            word_next = 1'b0;
            dest_mode_next = mode_data_reg;
            dest_reg_next = {2'h0, req_dest[0]};
            case (req_src[1:0])
               SRC2_REG:
               begin
                  src_mode_next = mode_data_reg;
                  src_reg_next = {2'h0, ~req_dest[0]};
                  bytes_next = LEN_ONE;
                  cycles_next = CYC_OR_SHORT_REG;
               end
               SRC2_D8_STATIC:
               begin
                  src_mode_next = mode_disp8_static_base;
                  bytes_next = LEN_TWO;
                  cycles_next = CYC_MEM3;
               end
               SRC2_D8_FRAME:
               begin
                  src_mode_next = mode_disp8_frame_base;
                  bytes_next = LEN_TWO;
                  cycles_next = CYC_MEM3;
               end
               default:
               begin
                  src_mode_next = mode_absolute_address_mode;
                  bytes_next = LEN_THREE;
                  cycles_next = CYC_MEM3;
               end
            endcase
         end
         op_pop_short, op_push_short:
         begin
            // One select bit; its meaning depends on size.
            if (req_size == SIZE_WORD)
               dest_mode_next = mode_address_reg;
            else
               dest_mode_next = mode_data_reg;
            dest_reg_next = {2'h0, req_dest[0]};
            bytes_next = LEN_ONE;
            cycles_next = (req_op == op_pop_short) ? CYC_POP : CYC_PUSH;
         end
         op_pop_control_register, op_push_control_register:
         begin
            dest_mode_next = mode_control_reg;
            dest_reg_next = req_dest[2:0];
            word_next = 1'b1;
            // Select 000 names nothing, so it is flagged rather than executed.
            illegal_next = (req_dest[2:0] == CTRL_INVALID);
            bytes_next = LEN_TWO;
            cycles_next = (req_op == op_pop_control_register) ? CYC_POP_CTRL : CYC_PUSH;
         end
         op_pop_multiple_registers:
         begin
            word_next = 1'b1;
            mask_next = req_mask;
            count_next = pop_count;
            bytes_next = LEN_TWO;
            if (pop_count <= 4'h1)
               cycles_next = CYC_MULTI_POP_SINGLE;
            else
               cycles_next = 5'(pop_count * CYC_MULTI_POP_PER_REG);
         end
         op_push_effective_address:
         begin
            src_mode_next = gen_mode(req_src);
            src_reg_next = gen_reg(req_src);
            word_next = 1'b1;
            illegal_next = (req_src < GEN_D8_ADDR_FIRST);
            bytes_next = LEN_TWO + gen_extra(req_src);
            cycles_next = CYC_PUSH_ADDR;
         end
         default: illegal_next = 1'b1;
      endcase
      // A fault is only reported for a request that is really there.
      illegal_next = illegal_next & req_valid;
   end

   ////////////////////////////////////////////////////////////////////////
   // Result registers; every output comes from here.

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         dec_valid <= 1'b0;
         dec_illegal <= 1'b0;
         dec_word <= 1'b0;
         dec_src_mode <= mode_none;
         dec_src_reg <= 3'h0;
         dec_dest_mode <= mode_none;
         dec_dest_reg <= 3'h0;
         dec_bytes <= 3'h0;
         dec_cycles <= 5'h00;
         dec_restore_mask <= 8'h00;
         dec_restore_count <= 4'h0;
      end
      else
      begin
         dec_valid <= valid_next;
         dec_illegal <= illegal_next;
         dec_word <= word_next;
         dec_src_mode <= src_mode_next;
         dec_src_reg <= src_reg_next;
         dec_dest_mode <= dest_mode_next;
         dec_dest_reg <= dest_reg_next;
         dec_bytes <= bytes_next;
         dec_cycles <= cycles_next;
         dec_restore_mask <= mask_next;
         dec_restore_count <= count_next;
      end
   end

endmodule

`default_nettype wire

// >>> logic_stack_op_props.sv
`timescale 1ns/10ps
`default_nettype none
module logic_stack_op_props
   import logic_stack_op_pkg::*;
(
   // Clock and reset.
   input wire logic clk,
   input wire logic resetn,
   // Request.
   input wire logic req_valid,
   input wire opcode_t req_op,
   input wire logic req_size,
   input wire logic [3:0] req_src,
   input wire logic [3:0] req_dest,
   input wire logic [7:0] req_mask,
   // Result.
   input wire logic dec_illegal,
   input wire logic dec_word,
   input wire mode_t dec_dest_mode,
   input wire logic [2:0] dec_bytes,
   input wire logic [4:0] dec_cycles,
   input wire logic [7:0] dec_restore_mask,
   input wire logic [3:0] dec_restore_count
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   logic [3:0] ones_reg;
   wire logic or_go = req_valid && req_op == op_or_general;
   wire logic pm_go = req_valid && req_op == op_pop_multiple_registers;
   wire logic ctl_go = req_valid && (req_op == op_pop_control_register
      || req_op == op_push_control_register);
   // The count is registered so that it lines up with the answer.
   always_ff @(posedge clk)
   begin
      ones_reg <= 4'($countones(req_mask));
   end
   property p_or_reg_src;
      or_go && req_src < 4'h6 |=> dec_cycles == ($past(req_dest) < 4'h6 ? 5'h02 : 5'h03);
   endproperty
   a_or_reg_src: assert property (p_or_reg_src) else $error("or reg source cycles");
   property p_or_mem_src;
      or_go && req_src > 4'h5 |=> dec_cycles == ($past(req_dest) < 4'h6 ? 5'h03 : 5'h04);
   endproperty
   a_or_mem_src: assert property (p_or_mem_src) else $error("or mem source cycles");
   property p_word;
      or_go |=> dec_word == $past(req_size);
   endproperty
   a_word: assert property (p_word) else $error("size bit");
   property p_imm_len;
      req_valid && req_op == op_push_imm_general |=> dec_bytes == 3'h3 + $past(req_size);
   endproperty
   a_imm_len: assert property (p_imm_len) else $error("immediate length");
   property p_pop_multiple_registers_cyc;
      pm_go && req_mask != 8'h00 |=> dec_cycles == (ones_reg == 4'h1 ? 5'h03 : {ones_reg, 1'b0});
   endproperty
   a_pop_multiple_registers_cyc: assert property (p_pop_multiple_registers_cyc) else $error("multi pop cycles");
   property p_pop_multiple_registers_mask;
      pm_go |=> dec_restore_mask == $past(req_mask) && dec_restore_count == ones_reg;
   endproperty
   a_pop_multiple_registers_mask: assert property (p_pop_multiple_registers_mask) else $error("multi pop mask");
   property p_ctrl;
      ctl_go |=> dec_illegal == ($past(req_dest[2:0]) == 3'h0);
   endproperty
   a_ctrl: assert property (p_ctrl) else $error("control select");
   property p_push_effective_address;
      req_valid && req_op == op_push_effective_address
         |=> dec_illegal != $past(req_src[3]) && (dec_illegal || dec_cycles == 5'h02);
   endproperty
   a_push_effective_address: assert property (p_push_effective_address) else $error("address push");
   property p_abs;
      req_valid && req_op == op_invert_general && req_dest == 4'hF
         |=> dec_dest_mode == mode_absolute_address_mode;
   endproperty
   a_abs: assert property (p_abs) else $error("absolute mode");
   c_or_mm: cover property (or_go && req_src > 4'h5 && req_dest > 4'h5);
   c_pop_multiple_registers: cover property (pm_go && req_mask == 8'hFF);
   c_ctrl_bad: cover property (ctl_go && req_dest[2:0] == 3'h0);
endmodule
bind logic_stack_op_decoder logic_stack_op_props chk (.clk(clk), .resetn(resetn),
   .req_valid(req_valid), .req_op(req_op), .req_size(req_size), .req_src(req_src),
   .req_dest(req_dest), .req_mask(req_mask), .dec_illegal(dec_illegal), .dec_word(dec_word),
   .dec_dest_mode(dec_dest_mode), .dec_bytes(dec_bytes), .dec_cycles(dec_cycles),
   .dec_restore_mask(dec_restore_mask), .dec_restore_count(dec_restore_count));
`default_nettype wire

// >>> prog_mem_model.sv
`timescale 1ns/10ps
`default_nettype none
module prog_mem_model
   import logic_stack_op_pkg::*;
(
   // Clock.
   input wire logic clk,
   // Fetched instruction fields.
   output logic req_valid,
   output opcode_t req_op,
   output logic req_size,
   output logic [3:0] req_src,
   output logic [3:0] req_dest,
   output logic [7:0] req_mask
);
   logic allow_bad = 1'b0;
   initial
   begin
      req_valid = 1'b0;
      req_op = op_invert_general;
      req_size = 1'b0;
      req_src = 4'h0;
      req_dest = 4'h0;
      req_mask = 8'h00;
   end
   task automatic send(opcode_t op, logic sz, logic [3:0] s, logic [3:0] d, logic [7:0] m);
      @(negedge clk);
      req_valid = 1'b1;
      req_op = op;
      req_size = sz;
      req_src = s;
      req_dest = d;
      req_mask = m;
      // Select zero is only fetched when a fault is wanted.
      if (!allow_bad && d[2:0] == 3'h0 && req_op inside {op_pop_control_register,
         op_push_control_register})
         req_dest = 4'h1;
   endtask
   // Idle source, destination and mask fields are inverted, so a stale value can never pass for a fresh one.
   task automatic idle();
      @(negedge clk);
      req_valid = 1'b0;
      req_src = ~req_src;
      req_dest = ~req_dest;
      req_mask = ~req_mask;
   endtask
endmodule
`default_nettype wire

// >>> tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top
   import logic_stack_op_pkg::*;
;
   typedef struct {
      logic ill;
      logic [4:0] cyc;
      logic [2:0] len;
      logic mchk;
      mode_t md;
      logic rchk;
      logic [2:0] rg;
      logic [7:0] msk;
      logic [3:0] cnt;
      logic schk;
      mode_t sm;
      logic [2:0] sr;
   } exp_t;
   logic clk;
   logic resetn;
   logic req_valid;
   opcode_t req_op;
   logic req_size;
   logic [3:0] req_src;
   logic [3:0] req_dest;
   logic [7:0] req_mask;
   logic dec_valid;
   logic dec_illegal;
   mode_t dec_dest_mode;
   mode_t dec_src_mode;
   logic [2:0] dec_src_reg;
   logic [2:0] dec_dest_reg;
   logic [2:0] dec_bytes;
   logic [4:0] dec_cycles;
   logic [7:0] dec_restore_mask;
   logic [3:0] dec_restore_count;
   exp_t q[$];
   exp_t e;
   int num_errors;
   int checks_done;
   int n;
   logic [3:0] c;
   logic [3:0] s;
   logic [7:0] m;
   logic [7:0] mtab [5] = '{8'h00, 8'h01, 8'h80, 8'h03, 8'hFF};
   mode_t smd [8] = '{mode_none, mode_none, mode_none, mode_data_reg, mode_data_reg,
      mode_disp8_static_base, mode_disp8_frame_base, mode_absolute_address_mode};
   mode_t gtab [16] = '{mode_data_reg, mode_data_reg, mode_data_reg, mode_data_reg,
      mode_address_reg, mode_address_reg, mode_indirect, mode_indirect, mode_disp8_address,
      mode_disp8_address, mode_disp8_static_base, mode_disp8_frame_base, mode_disp16_address,
      mode_disp16_address, mode_disp16_static_base, mode_absolute_address_mode};
   prog_mem_model pm (.clk(clk), .req_valid(req_valid), .req_op(req_op), .req_size(req_size),
      .req_src(req_src), .req_dest(req_dest), .req_mask(req_mask));
   logic_stack_op_decoder uut (.clk(clk), .resetn(resetn), .req_valid(req_valid),
      .req_op(req_op), .req_size(req_size), .req_src(req_src), .req_dest(req_dest),
      .req_mask(req_mask), .dec_valid(dec_valid), .dec_illegal(dec_illegal), .dec_word(),
      .dec_src_mode(dec_src_mode), .dec_src_reg(dec_src_reg), .dec_dest_mode(dec_dest_mode),
      .dec_dest_reg(dec_dest_reg), .dec_bytes(dec_bytes), .dec_cycles(dec_cycles),
      .dec_restore_mask(dec_restore_mask), .dec_restore_count(dec_restore_count));
   always #25 clk = ~clk;
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic gmem(logic [3:0] k);
      return k > 4'h5;
   endfunction
   function automatic logic [2:0] glen(logic [3:0] k);
      return k[3] ? (k[2] ? 3'h2 : 3'h1) : 3'h0;
   endfunction
   function automatic exp_t mk(logic ill, logic [4:0] cyc, logic [2:0] len);
      return '{ill, cyc, len, 1'b0, mode_none, 1'b0, 3'h0, 8'h00, 4'h0, 1'b0, mode_none, 3'h0};
   endfunction
   task automatic fail(string msg);
      num_errors++;
      $display("wrong value at %0t: %s", $time, msg);
   endtask
   task automatic check(exp_t x);
      checks_done++;
      if (dec_illegal !== x.ill)
         fail("illegal flag");
      else if (!x.ill && (dec_cycles !== x.cyc || dec_bytes !== x.len))
         fail("cycles or bytes");
      else if (!x.ill && (dec_restore_mask !== x.msk || dec_restore_count !== x.cnt))
         fail("restore mask");
      else if (!x.ill && x.mchk && dec_dest_mode !== x.md)
         fail("operand decode");
      else if (!x.ill && x.rchk && dec_dest_reg !== x.rg)
         fail("operand register");
      else if (!x.ill && x.schk && (dec_src_mode !== x.sm || dec_src_reg !== x.sr))
         fail("source decode");
   endtask
   task automatic go(opcode_t op, logic sz, logic [3:0] a, logic [3:0] b, logic [7:0] k, exp_t x);
      pm.send(op, sz, a, b, k);
      q.push_back(x);
   endtask
   task automatic print_verdict();
      if (num_errors == 0 && checks_done > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // Results are matched against the oldest note once they have settled.
   always @(posedge clk)
   begin
      #1;
      if (dec_valid === 1'b1)
      begin
         if (q.size() == 0)
            fail("unexpected result");
         else
            check(q.pop_front());
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      clk = 1'b0;
      resetn = 1'b0;
      num_errors = 0;
      checks_done = 0;
      void'($urandom(32'hFFD6BBE8));
      repeat (4) @(posedge clk);
      @(negedge clk) resetn = 1'b1;
      for (int i = 0; i < 32; i++)
      begin
         c = i[3:0];
         e = mk(1'b0, gmem(c) ? 5'h03 : 5'h01, 3'h2 + glen(c));
         e.mchk = 1'b1;
         e.md = gtab[c];
         e.rchk = (i[4] && c < 4'h4) || c == 4'h4 || c == 4'h5;
         e.rg = c < 4'h4 ? c[2:0] : {2'b00, c[0]};
         go(op_invert_general, i[4], 4'h0, c, 8'h00, e);
      end
      for (int i = 0; i < 48; i++)
      begin
         s = 4'($urandom);
         c = 4'($urandom);
         e = mk(1'b0, 5'h02 + gmem(s) + gmem(c), 3'h2 + glen(s) + glen(c));
         e.mchk = 1'b1;
         e.md = gtab[c];
         e.schk = s < 4'h6;
         e.sm = gtab[s];
         e.sr = s < 4'h4 ? s[2:0] : {2'b00, s[0]};
         go(op_or_general, i[0], s, c, 8'h00, e);
      end
      for (int i = 0; i < 16; i++)
      begin
         c = {1'b0, i[2:0]};
         e = mk(c < 4'h3, c < 4'h5 ? 5'h01 : 5'h03,
            (c < 4'h5 ? 3'h1 : (c < 4'h7 ? 3'h2 : 3'h3)) + i[3]);
         e.mchk = 1'b1;
         e.md = smd[c[2:0]];
         e.rchk = c < 4'h5;
         e.rg = {2'b00, c == 4'h3};
         go(i[3] ? op_or_imm_short : op_invert_short, 1'b0, 4'h0, c, 8'h00, e);
      end
      for (int i = 0; i < 8; i++)
      begin
         s = {2'b00, i[1:0]};
         e = mk(1'b0, s == 4'h0 ? 5'h02 : 5'h03, s == 4'h0 ? 3'h1 : (s == 4'h3 ? 3'h3 : 3'h2));
         e.mchk = 1'b1;
         e.md = mode_data_reg;
         e.rchk = 1'b1;
         e.rg = {2'b00, i[2]};
         e.schk = 1'b1;
         e.sm = s == 4'h0 ? mode_data_reg : (s == 4'h3 ? mode_absolute_address_mode
            : (s == 4'h1 ? mode_disp8_static_base : mode_disp8_frame_base));
         e.sr = {2'b00, s == 4'h0 && !i[2]};
         go(op_or_short, 1'b0, s, {3'b000, i[2]}, 8'h00, e);
      end
      for (int i = 0; i < 8; i++)
      begin
         e = mk(1'b0, (i[1] && !i[2]) ? 5'h04 : 5'h02, 3'h3 + i[0]);
         go(i[2] ? op_push_imm_general : op_or_imm_general, i[0], 4'h0,
            i[1] ? 4'h6 : 4'h0, 8'h00, e);
      end
      for (int i = 0; i < 10; i++)
      begin
         m = i < 5 ? mtab[i] : 8'($urandom);
         n = $countones(m);
         e = mk(1'b0, n > 1 ? 5'(2 * n) : 5'h03, 3'h2);
         e.msk = m;
         e.cnt = 4'(n);
         go(op_pop_multiple_registers, 1'b0, 4'h0, 4'h0, m, e);
      end
      pm.allow_bad = 1'b1;
      for (int i = 0; i < 16; i++)
      begin
         e = mk(i[2:0] == 3'h0, i[3] ? 5'h02 : 5'h03, 3'h2);
         go(i[3] ? op_push_control_register : op_pop_control_register, 1'b0, 4'h0,
            i[3:0], 8'h00, e);
      end
      for (int i = 0; i < 16; i++)
      begin
         c = i[3:0];
         e = mk(!c[3], 5'h02, 3'h2 + glen(c));
         go(op_push_effective_address, 1'b0, c, 4'h0, 8'h00, e);
      end
      for (int i = 0; i < 8; i++)
      begin
         e = mk(1'b0, i[2] ? 5'h02 : 5'h03, 3'h1);
         e.mchk = 1'b1;
         e.md = i[1] ? mode_address_reg : mode_data_reg;
         e.rchk = 1'b1;
         e.rg = {2'b00, i[0]};
         go(i[2] ? op_push_short : op_pop_short, i[1], {3'b000, i[0]}, {3'b000, i[0]},
            8'h00, e);
      end
      pm.idle();
      for (int k = 0; k < 10 && q.size() > 0; k++)
         @(posedge clk);
      if (q.size() != 0)
         fail("missing result");
      print_verdict();
   end
endmodule
`default_nettype wire
